//--- core/mol_margin_limits.sv
// Margin offset registers, loop reference slewing and percentage output limits.
// Assumes a PMBus layer handing over decoded commands and keeping status registers.
`timescale 1ns/10ps
module mol_margin_limits (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire mol_pkg::mol_req_s req_in,
    input  wire logic              loop_slave_in,
    input  wire logic              margin_high_restore_select_in,
    input  wire logic              margin_low_restore_select_in,
    input  wire logic [1:0]        operation_margin_in,
    input  wire logic [2:0]        ramp_state_in,
    input  wire logic              rise_tick_in,
    input  wire logic              transition_tick_in,
    input  wire logic              fall_tick_in,
    input  wire logic [15:0]       command_ref_in,
    input  wire logic [15:0]       trim_offset_in,
    input  wire logic [15:0]       vout_max_in,
    input  wire logic [15:0]       vout_min_in,
    input  wire logic [15:0]       feedback_pin_in,
    input  wire logic              alert_clear_in,
    output mol_pkg::mol_rsp_s      rsp_out,
    output logic [15:0]            loop_reference_out,
    output logic                   power_good_flag_out,
    output logic                   uv_warn_out,
    output logic                   ov_warn_out,
    output logic                   uv_fault_out,
    output logic                   ov_fault_out,
    output logic                   alert_out,
    output logic                   invalid_command_fault_out,
    output logic                   invalid_data_out,
    output logic                   communication_fault_bit_out
);
    import mol_pkg::*;

    logic [MH_BITS-1:0]  mh_r;
    logic [ML_BITS-1:0]  ml_r;
    logic [PCT_BITS-1:0] pct_r;
    mol_rsp_s            rsp_r;
    logic [15:0]         ref_r;
    logic                ivc_r;
    logic                ivd_r;
    logic                cf_r;
    logic                alert_r;
    logic                ovt_r;
    logic                uvt_r;
    logic                pg_r;
    logic                uvw_r;
    logic                ovw_r;
    logic                uvf_r;
    logic                ovf_r;

    logic                hit;
    logic                wr_ok;
    logic signed [17:0]  wdata;
    logic                mh_bad;
    logic                ml_bad;
    logic signed [17:0]  margin;
    logic signed [17:0]  raw_target;
    logic [15:0]         target;
    logic                tick;
    mol_thresh_s         th;
    logic                ovt_nxt;
    logic                uvt_nxt;

    assign hit   = req_in.valid &&
                   (req_in.code == CMD_MARGIN_HIGH || req_in.code == CMD_MARGIN_LOW ||
                    req_in.code == CMD_PCT_SELECT);
    assign wdata = 18'(signed'(req_in.data));
    assign wr_ok = hit && req_in.write && !loop_slave_in;
    assign mh_bad = wdata < MH_MIN || wdata > MH_MAX;
    assign ml_bad = wdata < ML_MIN || wdata > ML_MAX;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            mh_r <= margin_high_restore_select_in ? MH_RESTORE1[MH_BITS-1:0]
                                                  : MH_RESTORE0[MH_BITS-1:0];
        end else if (wr_ok && req_in.code == CMD_MARGIN_HIGH) begin
            if (wdata < MH_MIN)
                mh_r <= MH_MIN[MH_BITS-1:0];
            else if (wdata > MH_MAX)
                mh_r <= MH_MAX[MH_BITS-1:0];
            else
                mh_r <= wdata[MH_BITS-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ml_r <= margin_low_restore_select_in ? ML_RESTORE1[ML_BITS-1:0]
                                                 : ML_RESTORE0[ML_BITS-1:0];
        end else if (wr_ok && req_in.code == CMD_MARGIN_LOW) begin
            if (wdata < ML_MIN)
                ml_r <= ML_MIN[ML_BITS-1:0];
            else if (wdata > ML_MAX)
                ml_r <= ML_MAX[ML_BITS-1:0];
            else
                ml_r <= wdata[ML_BITS-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            pct_r <= PCT_RESET;
        else if (wr_ok && req_in.code == CMD_PCT_SELECT)
            pct_r <= req_in.data[PCT_BITS-1:0];
    end

    // Answer one cycle after the command; other codes belong to other blocks
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= hit;
            rsp_r.ack   <= hit && !loop_slave_in;
            rsp_r.data  <= 16'h0000;
            if (hit && !req_in.write && !loop_slave_in) begin
                unique case (req_in.code)
                    CMD_MARGIN_HIGH: rsp_r.data <= 16'(mh_r);
                    CMD_MARGIN_LOW:  rsp_r.data <= 16'(signed'(ml_r));
                    default:         rsp_r.data <= 16'(pct_r);
                endcase
            end
        end
    end

    // Fault pulses, alert sticky until cleared; a new event beats the clear
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ivc_r   <= 1'b0;
            ivd_r   <= 1'b0;
            cf_r    <= 1'b0;
            alert_r <= 1'b0;
        end else begin
            ivc_r <= hit && loop_slave_in;
            ivd_r <= wr_ok && ((req_in.code == CMD_MARGIN_HIGH && mh_bad) ||
                               (req_in.code == CMD_MARGIN_LOW && ml_bad));
            // Own flop so the status pin carries no gate after the register
            cf_r  <= (hit && loop_slave_in) ||
                     (wr_ok && ((req_in.code == CMD_MARGIN_HIGH && mh_bad) ||
                                (req_in.code == CMD_MARGIN_LOW && ml_bad)));
            if ((hit && loop_slave_in) || (wr_ok && (
                    (req_in.code == CMD_MARGIN_HIGH && mh_bad) ||
                    (req_in.code == CMD_MARGIN_LOW && ml_bad))))
                alert_r <= 1'b1;
            else if (alert_clear_in)
                alert_r <= 1'b0;
        end
    end

    always_comb begin
        unique case (operation_margin_in)
            OP_MARGIN_HIGH: margin = 18'(mh_r);
            OP_MARGIN_LOW:  margin = 18'(signed'(ml_r));
            OP_NOMINAL:     margin = 18'sh00000;
            default:        margin = 18'sh00000;
        endcase
        raw_target = signed'({2'b00, command_ref_in}) + 18'(signed'(trim_offset_in)) + margin;
        if (raw_target > signed'({2'b00, vout_max_in}))
            target = vout_max_in;
        else if (raw_target < signed'({2'b00, vout_min_in}))
            target = vout_min_in;
        else
            target = raw_target[15:0];
    end

    always_comb begin
        unique case (ramp_state_in)
            RAMP_SOFT_START: tick = rise_tick_in;
            RAMP_STEADY:     tick = transition_tick_in;
            RAMP_TOFF_DELAY: tick = transition_tick_in;
            RAMP_SOFT_STOP:  tick = fall_tick_in;
            RAMP_OFF:        tick = 1'b0;
            default:         tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in)
            ref_r <= 16'h0000;
        else if (tick && ref_r < target)
            ref_r <= ref_r + 16'h0001;
        else if (tick && ref_r > target)
            ref_r <= ref_r - 16'h0001;
    end

    assign th = mol_pct_table(pct_r);

    always_comb begin
        ovt_nxt = ovt_r;
        if (mol_above_pct(feedback_pin_in, ref_r, th.ov_warn))
            ovt_nxt = 1'b1;
        else if (mol_below_pct(feedback_pin_in, ref_r, PG_OV_RELEASE_PCT))
            ovt_nxt = 1'b0;
        uvt_nxt = uvt_r;
        if (mol_below_pct(feedback_pin_in, ref_r, th.uv_warn))
            uvt_nxt = 1'b1;
        else if (mol_above_pct(feedback_pin_in, ref_r, PG_UV_RELEASE_PCT))
            uvt_nxt = 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ovt_r <= 1'b0;
            uvt_r <= 1'b0;
            pg_r  <= 1'b0;
        end else begin
            ovt_r <= ovt_nxt;
            uvt_r <= uvt_nxt;
            pg_r  <= !(ovt_nxt || uvt_nxt);
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            uvw_r <= 1'b0;
            ovw_r <= 1'b0;
            uvf_r <= 1'b0;
            ovf_r <= 1'b0;
        end else begin
            uvw_r <= mol_below_pct(feedback_pin_in, ref_r, th.uv_warn);
            ovw_r <= mol_above_pct(feedback_pin_in, ref_r, th.ov_warn);
            uvf_r <= mol_below_pct(feedback_pin_in, ref_r, th.uv_fault);
            ovf_r <= mol_above_pct(feedback_pin_in, ref_r, th.ov_fault);
        end
    end

    assign rsp_out                     = rsp_r;
    assign loop_reference_out          = ref_r;
    assign power_good_flag_out         = pg_r;
    assign uv_warn_out                 = uvw_r;
    assign ov_warn_out                 = ovw_r;
    assign uv_fault_out                = uvf_r;
    assign ov_fault_out                = ovf_r;
    assign alert_out                   = alert_r;
    assign invalid_command_fault_out   = ivc_r;
    assign invalid_data_out            = ivd_r;
    assign communication_fault_bit_out = cf_r;

    a_slave_nack: assert property (@(posedge clk_in) disable iff (rst_in)
        hit && loop_slave_in |=> rsp_r.valid && !rsp_r.ack && ivc_r && alert_r)
        else $error("slave access not refused");
    a_slave_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
        hit && req_in.write && loop_slave_in |=> $stable(mh_r) && $stable(ml_r) && $stable(pct_r))
        else $error("slave write changed a register");
    a_mh_clamp: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ok && req_in.code == CMD_MARGIN_HIGH && wdata > MH_MAX |=> mh_r == 5'h1F && ivd_r)
        else $error("high offset not clamped");
    a_ml_clamp: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_ok && req_in.code == CMD_MARGIN_LOW && wdata < ML_MIN |=> ml_r == 7'h40 && ivd_r)
        else $error("low offset not clamped");
    a_mh_readzero: assert property (@(posedge clk_in) disable iff (rst_in)
        rsp_r.valid && rsp_r.ack && $past(req_in.code) == CMD_MARGIN_HIGH |->
        rsp_r.data[15:5] == 11'h000)
        else $error("high offset upper bits not zero");
    a_ml_signext: assert property (@(posedge clk_in) disable iff (rst_in)
        rsp_r.valid && rsp_r.ack && $past(req_in.code) == CMD_MARGIN_LOW &&
        !$past(req_in.write) |-> rsp_r.data[15:7] == 9'h1FF)
        else $error("low offset not sign extended");
    a_mh_restore: assert property (@(posedge clk_in)
        rst_in |=> mh_r == ($past(margin_high_restore_select_in) ? 5'h0F : 5'h09))
        else $error("high offset restore wrong");
    a_ml_restore: assert property (@(posedge clk_in)
        rst_in |=> ml_r == ($past(margin_low_restore_select_in) ? 7'h71 : 7'h77))
        else $error("low offset restore wrong");
    a_slew_step: assert property (@(posedge clk_in) disable iff (rst_in)
        !tick |=> $stable(ref_r))
        else $error("reference moved without a tick");
    a_target_bound: assert property (@(posedge clk_in) disable iff (rst_in)
        vout_min_in <= vout_max_in |-> target <= vout_max_in && target >= vout_min_in)
        else $error("target outside output limits");
    a_ov_hold: assert property (@(posedge clk_in) disable iff (rst_in)
        ovt_r && !mol_below_pct(feedback_pin_in, ref_r, PG_OV_RELEASE_PCT) |=> !pg_r)
        else $error("power good released above release point");
    a_pg_drop: assert property (@(posedge clk_in) disable iff (rst_in)
        mol_below_pct(feedback_pin_in, ref_r, th.uv_warn) |=> !pg_r && uvt_r)
        else $error("power good kept on under-voltage");

endmodule

//--- core/mol_pkg.sv
// Constants, types and table lookups for the margin offset and output limit bank.
// Assumes a PMBus command layer that delivers decoded command codes and data words.
package mol_pkg;

    // Command codes of the three registers
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'hD5;
    localparam logic [7:0] CMD_MARGIN_LOW  = 8'hD6;
    localparam logic [7:0] CMD_PCT_SELECT  = 8'hD7;

    // Values restored at reset, the margin ones chosen by the restore-select bits; PCT_RESET fixed
    localparam logic [15:0] MH_RESTORE0 = 16'h0009;
    localparam logic [15:0] MH_RESTORE1 = 16'h000F;
    localparam logic [15:0] ML_RESTORE0 = 16'hFFF7;
    localparam logic [15:0] ML_RESTORE1 = 16'hFFF1;
    localparam logic [1:0]  PCT_RESET   = 2'h0;

    // Linear format, fixed exponent, one step in microvolts
    localparam int          VOUT_EXPONENT = -9;
    localparam int          STEP_MICROVOLT = 1953;

    // Accepted offset ranges in steps
    localparam logic signed [17:0] MH_MIN = 18'sh00000;
    localparam logic signed [17:0] MH_MAX = 18'sh0001F;
    localparam logic signed [17:0] ML_MIN = -18'sh00040;
    localparam logic signed [17:0] ML_MAX = -18'sh00001;

    // Field layout
    localparam int MH_BITS  = 5;
    localparam int ML_BITS  = 7;
    localparam int PCT_BITS = 2;

    // Power-good release points, percent of the loop reference
    localparam logic [6:0] PG_OV_RELEASE_PCT = 7'h69;
    localparam logic [6:0] PG_UV_RELEASE_PCT = 7'h5F;
    localparam logic [6:0] PCT_SCALE         = 7'h64;

    typedef enum logic [2:0] {
        RAMP_OFF        = 3'b000,
        RAMP_SOFT_START = 3'b001,
        RAMP_STEADY     = 3'b010,
        RAMP_TOFF_DELAY = 3'b011,
        RAMP_SOFT_STOP  = 3'b100
    } mol_ramp_e;

    typedef enum logic [1:0] {
        OP_NOMINAL     = 2'b00,
        OP_MARGIN_LOW  = 2'b01,
        OP_MARGIN_HIGH = 2'b10
    } mol_margin_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  code;
        logic [15:0] data;
    } mol_req_s;

    typedef struct packed {
        logic        valid;
        logic        ack;
        logic [15:0] data;
    } mol_rsp_s;

    typedef struct packed {
        logic [6:0] uv_fault;
        logic [6:0] uv_warn;
        logic [6:0] ov_warn;
        logic [6:0] ov_fault;
    } mol_thresh_s;

    // Thresholds in percent of the loop reference
    function automatic mol_thresh_s mol_pct_table(input logic [1:0] sel);
        mol_thresh_s t;
        t = '{7'h53, 7'h58, 7'h70, 7'h75};
        unique case (sel)
            2'b00: t = '{7'h53, 7'h58, 7'h70, 7'h75};
            2'b01: t = '{7'h58, 7'h5A, 7'h6E, 7'h70};
            2'b10: t = '{7'h48, 7'h4E, 7'h70, 7'h75};
            2'b11: t = '{7'h3A, 7'h40, 7'h70, 7'h75};
        endcase
        return t;
    endfunction

    // True when the feedback exceeds pct percent of the reference
    function automatic logic mol_above_pct(input logic [15:0] fbv, input logic [15:0] refv,
                                           input logic [6:0] pct);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(fbv) * 24'(PCT_SCALE);
        rhs = 24'(refv) * 24'(pct);
        return lhs > rhs;
    endfunction

    function automatic logic mol_below_pct(input logic [15:0] fbv, input logic [15:0] refv,
                                           input logic [6:0] pct);
        logic [23:0] lhs;
        logic [23:0] rhs;
        lhs = 24'(fbv) * 24'(PCT_SCALE);
        rhs = 24'(refv) * 24'(pct);
        return lhs < rhs;
    endfunction

endpackage

//--- test/mol_host.sv
// Host model that hands decoded commands to the margin bank.
// Assumes the bank takes one request per rising edge and answers one cycle later.
`timescale 1ns/10ps
module mol_host (
    input  wire mol_pkg::mol_rsp_s rsp_in,
    input  wire logic              clk_in,
    output mol_pkg::mol_req_s      req_out
);
    import mol_pkg::*;
    int n_rsp;
    initial begin
        req_out = '0;
        n_rsp = 0;
    end
    // Content is judged by the bench model, only the count here
    always @(posedge clk_in) begin
        if (rsp_in.valid === 1'b1) begin
            n_rsp++;
        end
    end
    // Out-of-range data only when a test asks for it; gap 0 keeps valid up back to back
    task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        input int gap);
        @(negedge clk_in);
        req_out <= '{1'b1, wr, code, data};
        repeat (gap) begin
            @(negedge clk_in);
            req_out.valid <= 1'b0;
        end
    endtask
    task automatic idle();
        @(negedge clk_in);
        req_out <= '0;
    endtask
endmodule

//--- test/mol_margin_limits_tb.sv
// Self-checking bench for the margin offset and output limit bank.
// Assumes a cycle model here mirrors the bank and is compared at every falling edge.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module mol_margin_limits_tb;
    import mol_pkg::*;
    logic        clk_in, rst_in, slave, mh_sel, ml_sel, rise, trans, fall, clr;
    logic        pg, uvw, ovw, uvf, ovf, alert, icf, idf, cf;
    logic [1:0]  op, pct_m;
    logic [2:0]  ramp;
    logic [15:0] cmd, trim, vmax, vmin, fb, ref_o, mh_m, ml_m, ref_m;
    logic [31:0] rs;
    logic [7:0]  wc [11];
    logic [15:0] wd [11];
    logic        live, pg_m, uvw_m, ovw_m, uvf_m, ovf_m, al_m, ic_m, id_m, ovt, uvt;
    mol_req_s    req;
    mol_rsp_s    rsp, rsp_m;
    int          n_mismatch, n_checks, n_rsp_m, tgt, s, f100;
    int          uvf_t [4] = '{83, 88, 72, 58};
    int          uvw_t [4] = '{88, 90, 78, 64};
    int          ovw_t [4] = '{112, 110, 112, 112};
    int          ovf_t [4] = '{117, 112, 117, 117};

    mol_host host (.clk_in(clk_in), .rsp_in(rsp), .req_out(req));
    mol_margin_limits dut (.clk_in(clk_in), .rst_in(rst_in), .req_in(req),
        .loop_slave_in(slave), .margin_high_restore_select_in(mh_sel),
        .margin_low_restore_select_in(ml_sel), .operation_margin_in(op),
        .ramp_state_in(ramp), .rise_tick_in(rise), .transition_tick_in(trans),
        .fall_tick_in(fall), .command_ref_in(cmd), .trim_offset_in(trim),
        .vout_max_in(vmax), .vout_min_in(vmin), .feedback_pin_in(fb),
        .alert_clear_in(clr), .rsp_out(rsp), .loop_reference_out(ref_o),
        .power_good_flag_out(pg), .uv_warn_out(uvw), .ov_warn_out(ovw),
        .uv_fault_out(uvf), .ov_fault_out(ovf), .alert_out(alert),
        .invalid_command_fault_out(icf), .invalid_data_out(idf),
        .communication_fault_bit_out(cf));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Cycle model: comparators and targets use values from before this edge
    always @(posedge clk_in) begin
        live = 1'b1;
        if (rst_in) begin
            mh_m = mh_sel ? 16'h000F : 16'h0009;
            ml_m = ml_sel ? 16'hFFF1 : 16'hFFF7;
            {pct_m, ref_m, rsp_m, pg_m, uvw_m, ovw_m, uvf_m, ovf_m} = '0;
            {al_m, ic_m, id_m, ovt, uvt} = '0;
        end else begin
            f100 = int'(fb) * 100;
            uvw_m = f100 < int'(ref_m) * uvw_t[pct_m];
            ovw_m = f100 > int'(ref_m) * ovw_t[pct_m];
            uvf_m = f100 < int'(ref_m) * uvf_t[pct_m];
            ovf_m = f100 > int'(ref_m) * ovf_t[pct_m];
            ovt = ovw_m || (ovt && !(f100 < int'(ref_m) * 105));
            uvt = uvw_m || (uvt && !(f100 > int'(ref_m) * 95));
            pg_m = !(ovt || uvt);
            tgt = int'(cmd) + int'($signed(trim));
            tgt += (op == 2'b10) ? int'(mh_m) : (op == 2'b01) ? int'($signed(ml_m)) : 0;
            tgt = (tgt < int'(vmin)) ? int'(vmin) : (tgt > int'(vmax)) ? int'(vmax) : tgt;
            if ((ramp == 3'h1 && rise) || ((ramp == 3'h2 || ramp == 3'h3) && trans) ||
                (ramp == 3'h4 && fall)) begin
                ref_m = (int'(ref_m) < tgt) ? ref_m + 16'h1 :
                        (int'(ref_m) > tgt) ? ref_m - 16'h1 : ref_m;
            end
            {rsp_m, ic_m, id_m} = '0;
            if (req.valid && req.code inside {8'hD5, 8'hD6, 8'hD7}) begin
                rsp_m.valid = 1'b1;
                n_rsp_m++;
                s = int'($signed(req.data));
                if (slave) begin
                    ic_m = 1'b1;
                end else if (!req.write) begin
                    rsp_m.ack = 1'b1;
                    rsp_m.data = (req.code == 8'hD5) ? mh_m :
                                 (req.code == 8'hD6) ? ml_m : {14'h0, pct_m};
                end else begin
                    rsp_m.ack = 1'b1;
                    if (req.code == 8'hD5) begin
                        id_m = s < 0 || s > 31;
                        mh_m = 16'((s < 0) ? 0 : (s > 31) ? 31 : s);
                    end else if (req.code == 8'hD6) begin
                        id_m = s < -64 || s > -1;
                        ml_m = 16'((s < -64) ? -64 : (s > -1) ? -1 : s);
                    end else begin
                        pct_m = req.data[1:0];
                    end
                end
            end
            al_m = (al_m && !clr) || ic_m || id_m;
        end
    end

    always @(negedge clk_in) begin
        if (live === 1'b1) begin
            `CHK("rsp", rsp_m, rsp)
            `CHK("reference", ref_m, ref_o)
            `CHK("power_good", pg_m, pg)
            `CHK("warn_fault", {uvw_m, ovw_m, uvf_m, ovf_m}, {uvw, ovw, uvf, ovf})
            `CHK("alert", al_m, alert)
            `CHK("faults", {ic_m, id_m, ic_m | id_m}, {icf, idf, cf})
        end
    end

    task automatic close_out();
        `CHK("responses", n_rsp_m, host.n_rsp)
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic read_all(input string name);
        host.send(1'b0, 8'hD5, 16'h0000, 0);
        host.send(1'b0, 8'hD6, 16'h0000, 0);
        host.send(1'b0, 8'hD7, 16'h0000, 0);
        host.send(1'b0, 8'hD0, 16'h0000, 0);
        host.idle();
        repeat (2) @(negedge clk_in);
        $display("test %s done", name);
    endtask

    task automatic do_reset(input logic hs, input logic ls);
        @(negedge clk_in);
        {rst_in, mh_sel, ml_sel} = {1'b1, hs, ls};
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        n_mismatch++;
        close_out();
    end

    initial begin
        {rst_in, slave, mh_sel, ml_sel, rise, trans, fall, clr} = 8'h80;
        {op, ramp, trim, fb, n_mismatch, n_checks, n_rsp_m, live} = '0;
        {cmd, vmax, vmin} = {16'h00C8, 16'h00F0, 16'h00A0};
        rs = 32'h00016F4D;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        read_all("reset_defaults");
        wc = '{8'hD5, 8'hD5, 8'hD5, 8'hD5, 8'hD5, 8'hD6, 8'hD6, 8'hD6, 8'hD6, 8'hD6, 8'hD7};
        wd = '{16'h0020, 16'hFFFF, 16'h0000, 16'h001F, 16'(rs % 32), 16'h0000, 16'hFF00,
               16'h7FFF, 16'h8000, 16'(-1 - int'(rs[15:0] % 64)), 16'h00FE};
        foreach (wc[i]) begin
            host.send(1'b1, wc[i], wd[i], 0);
            host.send(1'b0, wc[i], 16'h0000, 0);
        end
        host.idle();
        @(negedge clk_in);
        clr = 1'b1;
        @(negedge clk_in);
        clr = 1'b0;
        read_all("write_clamp");
        slave = 1'b1;
        host.send(1'b1, 8'hD5, 16'h0001, 0);
        host.send(1'b0, 8'hD6, 16'h0000, 0);
        host.send(1'b1, 8'hD7, 16'h0003, 1);
        slave = 1'b0;
        read_all("loop_slave");
        for (int k = 0; k < 4; k++) begin
            host.send(1'b1, 8'hD7, 16'(k), 1);
            repeat (800) begin
                @(negedge clk_in);
                rs = lfsr_next(rs);
                {op, fall, trans, rise, ramp} = rs[7:0];
                trim = 16'($signed(rs[12:8]));
                clr = &rs[15:13];
                fb = 16'((int'(ref_m) * (50 + int'(rs[22:16]) % 81)) / 100);
            end
            $display("test limits_select_%0d done", k);
        end
        do_reset(1'b1, 1'b1);
        read_all("restore_select_one");
        close_out();
    end
endmodule
